// ### shared/ism_pkg.sv
// Constants, register map and state types of the single-master serial unit
package ism_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_SERIAL_CONTROL_ONE     = 8'h00;
  localparam logic [7:0] OFF_SERIAL_CONTROL_TWO     = 8'h04;
  localparam logic [7:0] OFF_SERIAL_MODE_ONE        = 8'h08;
  localparam logic [7:0] OFF_BUS_RATE_CONTROL       = 8'h0c;
  localparam logic [7:0] OFF_SERIAL_STATUS          = 8'h10;
  localparam logic [7:0] OFF_SERIAL_MODE_TWO        = 8'h14;
  localparam logic [7:0] OFF_MODULE_STANDBY_CONTROL = 8'h18;
  localparam logic [7:0] OFF_TRANSMIT_DATA          = 8'h1c;
  localparam logic [7:0] OFF_RECEIVE_DATA           = 8'h20;
  localparam logic [7:0] OFF_IRQ_MASK               = 8'h24;
  localparam logic [7:0] OFF_IRQ_STATUS             = 8'h28;
  localparam logic [2:0] WORD_SIZE                  = 3'h2;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CLOCK_SEL_LSB    = 0;
  localparam int DIRECTION_BIT    = 4;
  localparam int MASTER_ROLE_BIT  = 5;
  localparam int RX_CONTINUE_BIT  = 6;
  localparam int START_CMD_BIT    = 1;
  localparam int ACK_TX_LEVEL_BIT = 2;
  localparam int STOP_CMD_BIT     = 3;
  localparam int ACK_WAIT_BIT     = 3;
  localparam int BIT_ORDER_BIT    = 6;
  localparam int DATA_DELAY_LSB   = 4;
  localparam int RATE_HALF_BIT    = 6;
  localparam int RATE_DOUBLE_BIT  = 7;
  localparam int IFACE_TYPE_BIT   = 0;
  localparam int OWN_ADDR_LSB     = 1;
  localparam int STANDBY_BIT      = 0;
  localparam int ST_ACK_BIT       = 0;
  localparam int ST_BUSY_BIT      = 1;
  localparam int ST_STOP_BIT      = 3;
  localparam int ST_RX_FULL_BIT   = 5;
  localparam int ST_TX_DONE_BIT   = 6;
  localparam int IRQ_FRAME_BIT    = 0;
  localparam int IRQ_STOP_BIT     = 1;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [7:0] CONFIG_RST       = 8'h00;
  localparam logic       STANDBY_RST      = 1'b1;
  localparam logic [2:0] FULL_FRAME_CODE  = 3'h0;
  localparam logic [3:0] FULL_FRAME_BITS  = 4'h9;
  localparam logic [1:0] LAST_QUARTER     = 2'h3;
  localparam logic [1:0] WAIT_LAST_TICK   = 2'h3;
  localparam int         DELAY_BASE_TAP   = 2;
  localparam int         DELAY_STEP       = 2;
  localparam int         SHIFT_NORMAL     = 2;
  localparam int         SHIFT_DOUBLE     = 3;
  localparam int         SHIFT_HALF       = 1;
  // Bit-period divisors of the base clock, indexed by the clock select field
  localparam logic [15:0][8:0] CLOCK_DIV = {
    9'h100, 9'h0e0, 9'h0c8, 9'h0a0, 9'h080, 9'h060, 9'h050, 9'h038,
    9'h080, 9'h070, 9'h064, 9'h050, 9'h040, 9'h030, 9'h028, 9'h01c};

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ENG_IDLE, ENG_START, ENG_HOLD, ENG_BIT, ENG_WAIT, ENG_STOP
  } ism_eng_t;

  typedef struct packed {
    logic [3:0] clock_sel;
    logic       rate_double;
    logic       rate_half;
  } ism_rate_t;

  typedef struct packed {
    logic [7:0] cnt;
    logic       tick;
  } ism_rg_st_t;

  typedef struct packed {
    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    logic        sda_prev;
    logic        ap_valid;
    logic        ap_write;
    logic [7:0]  ap_addr;
    logic [31:0] hrdata;
    logic [7:0]  serial_control_one;
    logic [7:0]  serial_control_two;
    logic [7:0]  serial_mode_one;
    logic [7:0]  bus_rate_control;
    logic [7:0]  serial_mode_two;
    logic [7:0]  tx_data;
    logic [7:0]  rx_data;
    logic        standby;
    logic [1:0]  irq_mask;
    logic [1:0]  irq_status;
    logic        irq;
    logic        stop_flag;
    logic        rx_full_flag;
    logic        tx_done_flag;
    logic        ack_in;
    ism_eng_t    eng;
    logic [1:0]  ph;
    logic [3:0]  bitn;
    logic [7:0]  sh;
    logic [1:0]  wcnt;
    logic        scl_low;
    logic        sda_low;
    logic [8:0]  dline;
  } ism_core_st_t;

endpackage

// ### hw/ism_rate_gen.sv
// Quarter-bit tick generator for the serial transfer clock
`timescale 1ns/1ps
module ism_rate_gen (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              run,
  input  wire ism_pkg::ism_rate_t rate,
  output logic                   tick
);

  ism_pkg::ism_rg_st_t state_reg;
  ism_pkg::ism_rg_st_t state_next;
  logic [7:0]          quarter;

  // Bit period is four ticks, so the divisor is cut in quarters
  function automatic logic [7:0] quarter_of(input ism_pkg::ism_rate_t r);
    logic [8:0] d;
    logic [8:0] q;
    d = ism_pkg::CLOCK_DIV[r.clock_sel];
    if (r.rate_double)
      q = d >> ism_pkg::SHIFT_DOUBLE;
    else if (r.rate_half)
      q = d >> ism_pkg::SHIFT_HALF;
    else
      q = d >> ism_pkg::SHIFT_NORMAL;
    if (q == 9'h000)
      q = 9'h001;
    return q[7:0];
  endfunction

  assign quarter = quarter_of(rate);
  assign tick    = state_reg.tick;

  always_comb
  begin
    state_next = state_reg;
    state_next.tick = 1'b0;
    if (!run)
      state_next.cnt = 8'h00;
    else if (state_reg.cnt >= quarter - 8'h01)
    begin
      state_next.cnt  = 8'h00;
      state_next.tick = 1'b1;
    end
    else
      state_next.cnt = state_reg.cnt + 8'h01;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_reg <= '0;
    else
      state_reg <= state_next;
  end

endmodule // ism_rate_gen

// ### hw/ism_core.sv
// Single-master serial bus unit with AHB-Lite register slave
// How it works
// - Clock select 1000b gives a bit period of base clock divided by 56.
// - Direction bit clear means receive, set means transmit.
// - Master role bit clear means slave; master transfers need it set.
// - Receive continue clear in receive: reading receive data starts next byte.
// - Bit count 000b makes a frame of eight data bits plus acknowledge.
// - Acknowledge wait clear: acknowledge bit follows data bits with no gap.
// - Both rate modifiers clear: rate exactly as the clock select sets it.
// - Data delay 0 delays SDA output changes by three base clocks.
// - Status write with AND mask 97h clears stop, rx full, tx done only.
// - Seven-bit own address resets to 00h; interface select clear means bus.
// - Standby bit 1 stops the unit; it runs only with 0.
// - Interrupt on ninth rising SCL edge of a frame and on stop detect.
//
// Implementation choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ps
module ism_core (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             irq
);

  ism_pkg::ism_core_st_t state_reg;
  ism_pkg::ism_core_st_t state_next;
  ism_pkg::ism_rate_t    rate;
  logic                  tick;
  logic                  run;
  logic                  acc;
  logic                  wr;
  logic [7:0]            w;
  logic                  wr_tx;
  logic                  rd_rx;
  logic                  cmd_start;
  logic                  cmd_stop;
  logic                  active;
  logic                  is_master;
  logic                  is_tx;
  logic                  lsb_first;
  logic [3:0]            nbits;
  logic [3:0]            ack_pos;
  logic                  is_ack;
  logic                  stop_seen;
  logic [3:0]            tap;
  logic [7:0]            status_val;

  // Reverses the byte when least significant bit goes first
  function automatic logic [7:0] bit_order(input logic [7:0] x, input logic lsb);
    logic [7:0] r;
    r = x;
    if (lsb)
      for (int i = 0; i < 8; i++)
        r[i] = x[7 - i];
    return r;
  endfunction

  // ----------------------------------------------------------------
  // Rate generator
  // ----------------------------------------------------------------
  assign rate.clock_sel   = state_reg.serial_control_one[ism_pkg::CLOCK_SEL_LSB +: 4];
  assign rate.rate_double = state_reg.bus_rate_control[ism_pkg::RATE_DOUBLE_BIT];
  assign rate.rate_half   = state_reg.bus_rate_control[ism_pkg::RATE_HALF_BIT];
  assign run              = active && (state_reg.eng != ism_pkg::ENG_IDLE);

  ism_rate_gen u_rate (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     (run),
    .rate    (rate),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign tap = 4'(ism_pkg::DELAY_BASE_TAP + ism_pkg::DELAY_STEP *
               int'(state_reg.bus_rate_control[ism_pkg::DATA_DELAY_LSB +: 2]));
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = state_reg.hrdata;
  assign scl_o     = 1'b0;
  assign sda_o     = 1'b0;
  assign scl_oe    = state_reg.scl_low;
  assign sda_oe    = state_reg.dline[tap];
  assign irq       = state_reg.irq;

  // ----------------------------------------------------------------
  // Decoded controls
  // ----------------------------------------------------------------
  assign active    = !state_reg.standby
                     && !state_reg.serial_mode_two[ism_pkg::IFACE_TYPE_BIT];
  assign is_master = state_reg.serial_control_one[ism_pkg::MASTER_ROLE_BIT];
  assign is_tx     = state_reg.serial_control_one[ism_pkg::DIRECTION_BIT];
  assign lsb_first = state_reg.serial_mode_one[ism_pkg::BIT_ORDER_BIT];
  assign nbits     = (state_reg.serial_mode_one[2:0] == ism_pkg::FULL_FRAME_CODE)
                     ? ism_pkg::FULL_FRAME_BITS
                     : {1'b0, state_reg.serial_mode_one[2:0]} + 4'h1;
  assign ack_pos   = nbits - 4'h1;
  assign is_ack    = (state_reg.bitn == ack_pos);
  assign stop_seen = state_reg.scl_sync[1] && state_reg.sda_sync[1] && !state_reg.sda_prev;
  assign status_val = {1'b0, state_reg.tx_done_flag, state_reg.rx_full_flag, 1'b0,
                       state_reg.stop_flag, 1'b0,
                       (state_reg.eng != ism_pkg::ENG_IDLE), state_reg.ack_in};

  always_comb
  begin
    state_next = state_reg;
    w          = hwdata[7:0];
    acc        = hsel && hready && htrans[1] && (hsize == ism_pkg::WORD_SIZE);
    wr         = state_reg.ap_valid && state_reg.ap_write;
    wr_tx      = 1'b0;
    rd_rx      = 1'b0;
    cmd_start  = 1'b0;
    cmd_stop   = 1'b0;

    // Second flip-flop alone reads the first
    state_next.scl_sync = {state_reg.scl_sync[0], scl_i};
    state_next.sda_sync = {state_reg.sda_sync[0], sda_i};
    state_next.sda_prev = state_reg.sda_sync[1];
    state_next.dline    = {state_reg.dline[7:0], state_reg.sda_low};

    // ----------------------------------------------------------------
    // Bus address phase and reads
    // ----------------------------------------------------------------
    state_next.ap_valid = acc;
    state_next.ap_write = hwrite;
    state_next.ap_addr  = haddr[7:0];
    if (acc && !hwrite)
    begin
      if (haddr[7:0] == ism_pkg::OFF_SERIAL_CONTROL_ONE)
        state_next.hrdata = {24'h000000, state_reg.serial_control_one};
      else if (haddr[7:0] == ism_pkg::OFF_SERIAL_CONTROL_TWO)
        state_next.hrdata = {24'h000000, state_reg.serial_control_two};
      else if (haddr[7:0] == ism_pkg::OFF_SERIAL_MODE_ONE)
        state_next.hrdata = {24'h000000, state_reg.serial_mode_one};
      else if (haddr[7:0] == ism_pkg::OFF_BUS_RATE_CONTROL)
        state_next.hrdata = {24'h000000, state_reg.bus_rate_control};
      else if (haddr[7:0] == ism_pkg::OFF_SERIAL_STATUS)
        state_next.hrdata = {24'h000000, status_val};
      else if (haddr[7:0] == ism_pkg::OFF_SERIAL_MODE_TWO)
        state_next.hrdata = {24'h000000, state_reg.serial_mode_two};
      else if (haddr[7:0] == ism_pkg::OFF_MODULE_STANDBY_CONTROL)
        state_next.hrdata = {31'h00000000, state_reg.standby};
      else if (haddr[7:0] == ism_pkg::OFF_TRANSMIT_DATA)
        state_next.hrdata = {24'h000000, state_reg.tx_data};
      else if (haddr[7:0] == ism_pkg::OFF_RECEIVE_DATA)
      begin
        state_next.hrdata       = {24'h000000, state_reg.rx_data};
        state_next.rx_full_flag = 1'b0;
        rd_rx                   = 1'b1;
      end
      else if (haddr[7:0] == ism_pkg::OFF_IRQ_MASK)
        state_next.hrdata = {30'h00000000, state_reg.irq_mask};
      else if (haddr[7:0] == ism_pkg::OFF_IRQ_STATUS)
      begin
        state_next.hrdata     = {30'h00000000, state_reg.irq_status};
        state_next.irq_status = 2'h0;
      end
      else
        state_next.hrdata = 32'h00000000;
    end

    // ----------------------------------------------------------------
    // Bus data phase writes
    // ----------------------------------------------------------------
    if (wr)
    begin
      if (state_reg.ap_addr == ism_pkg::OFF_SERIAL_CONTROL_ONE)
        state_next.serial_control_one = w;
      else if (state_reg.ap_addr == ism_pkg::OFF_SERIAL_CONTROL_TWO)
      begin
        // Start and stop are strobes and never stored
        state_next.serial_control_two = w;
        state_next.serial_control_two[ism_pkg::START_CMD_BIT] = 1'b0;
        state_next.serial_control_two[ism_pkg::STOP_CMD_BIT]  = 1'b0;
        cmd_start = w[ism_pkg::START_CMD_BIT];
        cmd_stop  = w[ism_pkg::STOP_CMD_BIT];
      end
      else if (state_reg.ap_addr == ism_pkg::OFF_SERIAL_MODE_ONE)
        state_next.serial_mode_one = w;
      else if (state_reg.ap_addr == ism_pkg::OFF_BUS_RATE_CONTROL)
        state_next.bus_rate_control = w;
      else if (state_reg.ap_addr == ism_pkg::OFF_SERIAL_STATUS)
      begin
        // Writing 0 clears a flag, writing 1 leaves it
        state_next.stop_flag    = state_next.stop_flag && w[ism_pkg::ST_STOP_BIT];
        state_next.rx_full_flag = state_next.rx_full_flag && w[ism_pkg::ST_RX_FULL_BIT];
        state_next.tx_done_flag = state_next.tx_done_flag && w[ism_pkg::ST_TX_DONE_BIT];
      end
      else if (state_reg.ap_addr == ism_pkg::OFF_SERIAL_MODE_TWO)
        state_next.serial_mode_two = w;
      else if (state_reg.ap_addr == ism_pkg::OFF_MODULE_STANDBY_CONTROL)
        state_next.standby = w[ism_pkg::STANDBY_BIT];
      else if (state_reg.ap_addr == ism_pkg::OFF_TRANSMIT_DATA)
      begin
        state_next.tx_data      = w;
        state_next.tx_done_flag = 1'b0;
        wr_tx                   = 1'b1;
      end
      else if (state_reg.ap_addr == ism_pkg::OFF_IRQ_MASK)
        state_next.irq_mask = w[1:0];
    end

    // ----------------------------------------------------------------
    // Bit engine
    // ----------------------------------------------------------------
    case (state_reg.eng)
      ism_pkg::ENG_IDLE:
      begin
        state_next.scl_low = 1'b0;
        state_next.sda_low = 1'b0;
        if (cmd_start && is_master)
        begin
          state_next.eng     = ism_pkg::ENG_START;
          state_next.ph      = 2'h0;
          state_next.sda_low = 1'b1;
        end
      end
      ism_pkg::ENG_START:
        if (tick)
        begin
          state_next.ph = state_reg.ph + 2'h1;
          if (state_reg.ph == 2'h1)
          begin
            state_next.scl_low = 1'b1;
            state_next.eng     = ism_pkg::ENG_HOLD;
          end
        end
      ism_pkg::ENG_HOLD:
        if (cmd_stop)
        begin
          state_next.eng     = ism_pkg::ENG_STOP;
          state_next.ph      = 2'h0;
          state_next.sda_low = 1'b1;
        end
        else if (wr_tx || (rd_rx && !is_tx
                 && !state_reg.serial_control_one[ism_pkg::RX_CONTINUE_BIT]))
        begin
          // Receive releases SDA because data bits drive it low only when is_tx is set
          state_next.sh   = is_tx ? bit_order(w, lsb_first) : 8'hff;
          state_next.bitn = 4'h0;
          state_next.ph   = 2'h0;
          state_next.eng  = ism_pkg::ENG_BIT;
        end
      ism_pkg::ENG_BIT:
        if (tick)
        begin
          case (state_reg.ph)
            2'h0:
            begin
              if (is_ack)
                state_next.sda_low = !is_tx
                                     && !state_reg.serial_control_two[ism_pkg::ACK_TX_LEVEL_BIT];
              else
                state_next.sda_low = is_tx && !state_reg.sh[7];
              state_next.ph = 2'h1;
            end
            2'h1:
            begin
              state_next.scl_low = 1'b0;
              state_next.ph      = 2'h2;
              if (is_ack)
                state_next.irq_status[ism_pkg::IRQ_FRAME_BIT] = 1'b1;
            end
            2'h2:
              // A slave holding SCL low stretches the low phase
              if (state_reg.scl_sync[1])
              begin
                if (is_ack)
                  state_next.ack_in = state_reg.sda_sync[1];
                else
                  state_next.sh = {state_reg.sh[6:0], state_reg.sda_sync[1]};
                state_next.ph = ism_pkg::LAST_QUARTER;
              end
            default:
            begin
              state_next.scl_low = 1'b1;
              state_next.ph      = 2'h0;
              state_next.bitn    = state_reg.bitn + 4'h1;
              if (is_ack)
              begin
                state_next.eng = ism_pkg::ENG_HOLD;
                if (is_tx)
                  state_next.tx_done_flag = 1'b1;
                else
                begin
                  state_next.rx_full_flag = 1'b1;
                  state_next.rx_data      = bit_order(state_reg.sh, lsb_first);
                end
              end
              else if ((state_reg.bitn == ack_pos - 4'h1)
                       && state_reg.serial_mode_one[ism_pkg::ACK_WAIT_BIT])
              begin
                state_next.eng  = ism_pkg::ENG_WAIT;
                state_next.wcnt = 2'h0;
              end
            end
          endcase
        end
      ism_pkg::ENG_WAIT:
        if (tick)
        begin
          state_next.wcnt = state_reg.wcnt + 2'h1;
          if (state_reg.wcnt == ism_pkg::WAIT_LAST_TICK)
            state_next.eng = ism_pkg::ENG_BIT;
        end
      ism_pkg::ENG_STOP:
        if (tick)
        begin
          // SDA low for a whole quarter before SCL goes; the free-running tick may come right after entry
          if (state_reg.ph != 2'h2)
          begin
            state_next.scl_low = (state_reg.ph == 2'h0);
            state_next.ph      = state_reg.ph + 2'h1;
          end
          else if (state_reg.scl_sync[1])
          begin
            state_next.sda_low = 1'b0;
            state_next.eng     = ism_pkg::ENG_IDLE;
          end
        end
      default:
        state_next.eng = ism_pkg::ENG_IDLE;
    endcase

    // Standby or the other interface type releases SCL at once and SDA after the data delay line
    if (!active)
    begin
      state_next.eng     = ism_pkg::ENG_IDLE;
      state_next.scl_low = 1'b0;
      state_next.sda_low = 1'b0;
      state_next.ph      = 2'h0;
    end

    if (stop_seen)
    begin
      state_next.stop_flag                        = 1'b1;
      state_next.irq_status[ism_pkg::IRQ_STOP_BIT] = 1'b1;
    end
    state_next.irq = |(state_next.irq_status & state_next.irq_mask);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_reg                    <= '0;
      state_reg.scl_sync           <= 2'h3;
      state_reg.sda_sync           <= 2'h3;
      state_reg.sda_prev           <= 1'b1;
      state_reg.serial_control_one <= ism_pkg::CONFIG_RST;
      state_reg.serial_control_two <= ism_pkg::CONFIG_RST;
      state_reg.serial_mode_one    <= ism_pkg::CONFIG_RST;
      state_reg.bus_rate_control   <= ism_pkg::CONFIG_RST;
      state_reg.serial_mode_two    <= ism_pkg::CONFIG_RST;
      state_reg.standby            <= ism_pkg::STANDBY_RST;
      state_reg.eng                <= ism_pkg::ENG_IDLE;
    end
    else
      state_reg <= state_next;
  end

endmodule // ism_core

// ### bench/ism_core_assertions.sv
// Bus and line checker for the serial unit
`timescale 1ns/1ps
module ism_core_assertions (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_o,
  input wire logic        sda_oe
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [7:0] rel_cnt;
  // Saturates so an idle bus never wraps into a bit-sized span
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) rel_cnt <= 8'hff;
    else if (scl_oe) rel_cnt <= 8'h00;
    else if (rel_cnt != 8'hff) rel_cnt <= rel_cnt + 8'h01;
  sequence s_start;
    !scl_oe && $rose(sda_oe);
  endsequence
  a_resp_okay:
    assert property (hresp == 1'b0) else $error("bus error response");
  a_ready_high:
    assert property (hreadyout == 1'b1) else $error("wait state inserted");
  a_rdata_upper:
    assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
  a_rdata_hold:
    assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata)) else $error("read data moved");
  a_lines_open:
    assert property (scl_o == 1'b0 && sda_o == 1'b0) else $error("line driven high");
  a_start_gap:
    assert property (s_start |-> ##[22:34] $rose(scl_oe)) else $error("start timing wrong");
  a_scl_release:
    assert property ($rose(scl_oe) |-> (rel_cnt inside {[8'd26:8'd32]} || rel_cnt > 8'd40)) else $error("bad high");
  a_sda_steady:
    assert property ($fell(scl_oe) |=> $stable(sda_oe) [*8]) else $error("data moved with clock high");
endmodule // ism_core_assertions

bind ism_core ism_core_assertions i_ism_core_assertions (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
  .hreadyout, .hresp, .hrdata, .scl_o, .scl_oe, .sda_o, .sda_oe);

// ### bench/ism_slave_model.sv
// Behavioural bus slave: acks writes, answers reads with a fixed byte
`timescale 1ns/1ps
module ism_slave_model #(
  parameter logic [7:0] READ_BYTE = 8'ha5
) (
  input  wire logic scl,
  input  wire logic sda,
  output logic      pull
);
  logic [3:0] bitc;
  logic [7:0] sh;
  logic       first;
  logic       rd;
  initial {pull, bitc, sh, first, rd} = '0;
  always @(negedge sda) if (scl) {bitc, first, pull} = {4'h0, 2'b10};
  always @(posedge sda) if (scl) {first, rd, pull} = 3'b000;
  always @(posedge scl)
    if (bitc == 4'h8)
    begin
      bitc = 4'h0;
      if (first) rd = sh[0];
      else if (sda) rd = 1'b0;
      first = 1'b0;
    end
    else
    begin
      sh = {sh[6:0], sda};
      bitc = bitc + 4'h1;
    end
  // Lets go after a refused byte so the master can stop
  always @(negedge scl)
    pull = (bitc == 4'h8) ? (first || !rd) : (rd && !READ_BYTE[7 - bitc]);
endmodule // ism_slave_model

// ### bench/testbench.sv
// Self-checking bench for the serial unit
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, scl_oe, sda_oe, irq, pull;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  int          fails = 0, total_checks = 0, nr;
  time         t1, t9;
  wire         scl = !scl_oe;
  wire         sda = !(sda_oe || pull);
  ism_core i_ism_core (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
    .hreadyout, .hresp, .hrdata, .scl_i(scl), .scl_o(), .scl_oe, .sda_i(sda), .sda_o(), .sda_oe, .irq);
  ism_slave_model i_ism_slave_model (.scl, .sda, .pull);
  initial
  begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  always @(posedge scl)
  begin
    nr++;
    if (nr == 1) t1 = $time;
    if (nr == 9) t9 = $time;
  end
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge hclk);
    {hsel, hwrite, htrans, hsize, haddr} <= {1'b1, w, 2'b10, ism_pkg::WORD_SIZE, 24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans} <= 3'b000;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d); bus(1'b1, a, d); endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e); bus(1'b0, a, 8'h0); `CHK(r, {24'h0, e}) endtask
  task automatic wait_hold; repeat (200) if (!scl_oe) @(posedge hclk); endtask
  // A frame interrupt comes at the ninth rising SCL edge; flags settle only once SCL is held low again
  task automatic wait_irq; repeat (2000) if (irq !== 1'b1) @(posedge hclk); wait_hold; endtask
  task automatic t_start(input logic [7:0] ctl, input logic [7:0] adr);
    wr(8'h00, ctl);
    wr(8'h04, 8'hf7);
    wait_hold;
    repeat (4) @(posedge hclk);
    nr = 0;
    wr(8'h1c, adr);
    wait_irq;
  endtask
  task automatic t_reset;
    for (int i = 0; i < 6; i++) rd(8'(i * 4), 8'h00);
    rd(8'h18, 8'h01);
    rd(8'h2c, 8'h00);
    wr(8'h00, 8'hb8);
    wr(8'h04, 8'hf7);
    repeat (40) @(posedge hclk);
    rd(8'h10, 8'h00);
  endtask
  task automatic t_init;
    logic [7:0] v [4] = '{8'h88, 8'hf5, 8'h10, 8'h0f};
    for (int i = 0; i < 4; i++) wr(8'(i * 4), v[i]);
    wr(8'h10, 8'h97);
    wr(8'h14, 8'h00);
    wr(8'h18, 8'h00);
    for (int i = 0; i < 4; i++) rd(8'(i * 4), v[i]);
    wr(8'h04, 8'hf7);
    repeat (40) @(posedge hclk);
    rd(8'h10, 8'h00);
  endtask
  task automatic t_write;
    wr(8'h24, 8'h03);
    t_start(8'hb8, 8'ha0);
    `CHK(nr, 9)
    `CHK(t9 - t1, 64'd1792)
    rd(8'h28, 8'h01);
    rd(8'h10, 8'h42);
    wr(8'h04, 8'hfd);
    wait_irq;
    rd(8'h28, 8'h02);
    rd(8'h10, 8'h48);
    wr(8'h10, 8'h97);
    rd(8'h10, 8'h00);
  endtask
  task automatic t_read;
    wr(8'h24, 8'h01);
    t_start(8'hb8, 8'ha1);
    rd(8'h28, 8'h01);
    wr(8'h00, 8'ha8);
    bus(1'b0, 8'h20, 8'h00);
    wait_irq;
    rd(8'h28, 8'h01);
    rd(8'h10, 8'h63);
    wr(8'h04, 8'hfd);
    repeat (500) if (!(scl && sda)) @(posedge hclk);
    repeat (8) @(posedge hclk);
    `CHK(irq, 1'b0)
    rd(8'h28, 8'h02);
    wr(8'h00, 8'h88);
    rd(8'h20, 8'ha5);
    bus(1'b0, 8'h10, 8'h00);
    `CHK(r[5], 1'b0)
  endtask
  task automatic end_sim;
    if (fails == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial
  begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_init;
    t_write;
    t_read;
    end_sim;
  end
  initial
  begin
    #100000;
    fails++;
    end_sim;
  end
endmodule // testbench
